// ==== design/lcrsd_driver.sv ====
// Purpose: Common row scan shift register with four-level selection
// Assumes: All pins synchronous to clock_i, shift clock far slower
// Notes:   Chain bits pass through a small FIFO before the register
`timescale 1ns/100ps
`default_nettype none

// --------------------------------------------------------------------
// Synchronous FIFO
// --------------------------------------------------------------------
module lcrsd_fifo #(
  parameter int unsigned WIDTH = 2,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input  wire logic                     clock_i,
  input  wire logic                     rst_b_i,
  // Fill side
  input  wire logic                     in_valid_i,
  output logic                          in_ready_o,
  input  wire logic [WIDTH-1:0]         in_data_i,
  // Drain side
  output logic                          out_valid_o,
  input  wire logic                     out_ready_i,
  output logic      [WIDTH-1:0]         out_data_o,
  // Fill level
  output logic      [$clog2(DEPTH):0]   level_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      wr_d;
  logic [AW:0]      rd_q;
  logic [AW:0]      rd_d;
  logic             push;
  logic             pop;
  // Full when pointers differ only in the wrap bit
  assign level_o     = wr_q - rd_q;
  assign in_ready_o  = (level_o != (AW+1)'(DEPTH));
  assign out_valid_o = (wr_q != rd_q);
  assign out_data_o  = mem_q[rd_q[AW-1:0]];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  // Next pointer values
  always_comb
  begin
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
  end
  // Pointer registers
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end
  // Storage, no reset needed
  always_ff @(posedge clock_i)
  begin
    if (push)
      mem_q[wr_q[AW-1:0]] <= in_data_i;
  end
endmodule

// --------------------------------------------------------------------
// Row scan driver top
// --------------------------------------------------------------------
module lcrsd_driver #(
  parameter int unsigned               STAGES      = lcrsd_pkg::STAGES,
  parameter int unsigned               FIFO_DEPTH  = lcrsd_pkg::FIFO_DEPTH,
  parameter lcrsd_pkg::lcrsd_level_e   BLANK_LEVEL = lcrsd_pkg::select_level_low
) (
  // Clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  rst_b_i,
  // Scan control from timing controller
  input  wire logic                  line_shift_clock_i,
  input  wire logic                  shift_direction_select_i,
  input  wire logic                  polarity_alternate_i,
  input  wire logic                  display_blank_n_i,
  // Left chain port, two-way
  input  wire logic                  left_chain_port_i,
  output logic                       left_chain_port_o,
  output logic                       left_chain_port_oe_b_o,
  // Right chain port, two-way
  input  wire logic                  right_chain_port_i,
  output logic                       right_chain_port_o,
  output logic                       right_chain_port_oe_b_o,
  // Common drive level codes, two bits per output
  output logic [STAGES-1:0][1:0]     common_drive_outputs_o,
  // Chain input acceptance
  output logic                       scan_ready_o,
  // Register port
  input  wire logic [7:0]            reg_addr_i,
  input  wire logic [31:0]           reg_wdata_i,
  input  wire logic                  reg_write_i,
  input  wire logic                  reg_read_i,
  output logic [31:0]                reg_rdata_o
);
  localparam int unsigned LW = $clog2(FIFO_DEPTH) + 1;

  // ------------------------------------------------------------------
  // Shift clock edge detect
  // ------------------------------------------------------------------
  logic clk_prev_q;
  logic clk_prev_d;
  logic fall;
  always_comb
  begin
    clk_prev_d = line_shift_clock_i;
  end
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      clk_prev_q <= 1'b0;
    else
      clk_prev_q <= clk_prev_d;
  end
  assign fall = clk_prev_q && !line_shift_clock_i;

  // ------------------------------------------------------------------
  // Chain input FIFO, entries hold {direction, bit}
  // ------------------------------------------------------------------
  logic          in_bit;
  logic          pop_valid;
  logic          pop_ready;
  logic [1:0]    pop_data;
  logic [LW-1:0] fifo_level;
  logic [1:0]    ctrl_q;
  logic [1:0]    ctrl_d;
  // Entry port follows direction select
  assign in_bit    = shift_direction_select_i ? right_chain_port_i
                                              : left_chain_port_i;
  assign pop_ready = !ctrl_q[lcrsd_pkg::CTRL_HOLD_BIT];
  lcrsd_fifo #(
    .WIDTH (2),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_i     (clock_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (fall),
    .in_ready_o  (scan_ready_o),
    .in_data_i   ({shift_direction_select_i, in_bit}),
    .out_valid_o (pop_valid),
    .out_ready_i (pop_ready),
    .out_data_o  (pop_data),
    .level_o     (fifo_level)
  );
  // ------------------------------------------------------------------
  // Bidirectional shift register
  // ------------------------------------------------------------------
  logic [STAGES-1:0] stage_q;
  logic [STAGES-1:0] stage_d;

  // Low direction moves toward the last stage, high toward the first
  always_comb
  begin
    stage_d = stage_q;
    if (pop_valid && pop_ready)
    begin
      if (!pop_data[1])
        stage_d = {stage_q[STAGES-2:0], pop_data[0]};
      else
        stage_d = {pop_data[0], stage_q[STAGES-1:1]};
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      stage_q <= '0;
    else
      stage_q <= stage_d;
  end

  // Outgoing port drives the bit now held in the far stage
  assign right_chain_port_o      = stage_q[STAGES-1];
  assign left_chain_port_o       = stage_q[0];
  assign right_chain_port_oe_b_o = shift_direction_select_i;
  assign left_chain_port_oe_b_o  = !shift_direction_select_i;

  // ------------------------------------------------------------------
  // Drive level selection per output
  // ------------------------------------------------------------------
  logic [STAGES-1:0][1:0] drive_d;
  logic [STAGES-1:0][1:0] drive_q;
  logic                   blank;

  assign blank = !display_blank_n_i || ctrl_q[lcrsd_pkg::CTRL_BLANK_BIT];

  for (genvar g = 0; g < STAGES; g++)
  begin : g_level
    always_comb
    begin
      if (blank)
        drive_d[g] = BLANK_LEVEL;
      else if (!polarity_alternate_i)
        drive_d[g] = stage_q[g] ? lcrsd_pkg::unselect_level_low
                                : lcrsd_pkg::unselect_level_high;
      else
        drive_d[g] = stage_q[g] ? lcrsd_pkg::select_level_high
                                : lcrsd_pkg::unselect_level_low;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      drive_q <= {STAGES{BLANK_LEVEL}};
    else
      drive_q <= drive_d;
  end

  assign common_drive_outputs_o = drive_q;

  // ------------------------------------------------------------------
  // Register port
  // ------------------------------------------------------------------
  logic        ovf_q;
  logic        ovf_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [95:0] stage_wide;

  assign stage_wide = 96'(stage_q);

  // Control write, overflow sticky with set beating clear
  always_comb
  begin
    ctrl_d = ctrl_q;
    ovf_d  = ovf_q;
    if (reg_write_i && reg_addr_i == lcrsd_pkg::ADDR_CTRL)
      ctrl_d = reg_wdata_i[1:0];
    if (reg_write_i && reg_addr_i == lcrsd_pkg::ADDR_STATUS
        && reg_wdata_i[lcrsd_pkg::STAT_OVF_BIT])
      ovf_d = 1'b0;
    if (fall && !scan_ready_o)
      ovf_d = 1'b1;
  end

  // Read data, present only in the cycle after the strobe
  always_comb
  begin
    rdata_d = '0;
    if (reg_read_i)
    begin
      unique case (reg_addr_i)
        lcrsd_pkg::ADDR_CTRL:   rdata_d = {30'h0, ctrl_q};
        lcrsd_pkg::ADDR_STATUS: rdata_d = 32'(
          {fifo_level, 3'h0, ovf_q});
        lcrsd_pkg::ADDR_STAGE0: rdata_d = stage_wide[31:0];
        lcrsd_pkg::ADDR_STAGE1: rdata_d = stage_wide[63:32];
        lcrsd_pkg::ADDR_STAGE2: rdata_d = stage_wide[95:64];
        default:                rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ctrl_q  <= lcrsd_pkg::CTRL_RESET;
      ovf_q   <= lcrsd_pkg::OVF_RESET;
      rdata_q <= '0;
    end
    else
    begin
      ctrl_q  <= ctrl_d;
      ovf_q   <= ovf_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  sequence s_idle_fall;
    fall && scan_ready_o && fifo_level == '0 && pop_ready;
  endsequence
  sequence s_pop_right;
    pop_valid && pop_ready && !pop_data[1];
  endsequence
  sequence s_pop_left;
    pop_valid && pop_ready && pop_data[1];
  endsequence
  a_fall_enters_stage: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    s_idle_fall ##0 !shift_direction_select_i |->
      ##2 stage_q[0] == $past(left_chain_port_i, 2))
    else $error("fall bit not in first stage");
  a_shift_toward_last: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    s_pop_right |=> stage_q[STAGES-1:1] == $past(stage_q[STAGES-2:0]))
    else $error("right shift wrong");
  a_shift_toward_first: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    s_pop_left |=> stage_q[STAGES-2:0] == $past(stage_q[STAGES-1:1])
      && stage_q[STAGES-1] == $past(pop_data[0]))
    else $error("left shift wrong");
  a_chain_out_ports: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    !shift_direction_select_i |-> !right_chain_port_oe_b_o
      && left_chain_port_oe_b_o && right_chain_port_o == stage_q[STAGES-1])
    else $error("outgoing port wrong");
  a_level_pol_low: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    rst_b_i && !blank && !polarity_alternate_i |=>
      drive_q[0] == ($past(stage_q[0]) ? lcrsd_pkg::unselect_level_low
                                       : lcrsd_pkg::unselect_level_high))
    else $error("low polarity level wrong");
  a_level_pol_high: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    rst_b_i && !blank && polarity_alternate_i |=>
      drive_q[STAGES-1] == ($past(stage_q[STAGES-1])
        ? lcrsd_pkg::select_level_high : lcrsd_pkg::unselect_level_low))
    else $error("high polarity level wrong");
  a_blank_all_out: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    !display_blank_n_i |=> drive_q == {STAGES{BLANK_LEVEL}})
    else $error("blank not applied");
  a_ovf_on_full: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    fall && !scan_ready_o |=> ovf_q)
    else $error("overflow not flagged");
endmodule

`default_nettype wire

// ==== design/lcrsd_pkg.sv ====
// Purpose: Constants and types for the LCD common row scan driver
// Assumes: 250 MHz system clock, plain register port
// Notes:   Level codes name the four drive voltages
`default_nettype none
package lcrsd_pkg;

  // ----------------------------------------------------------------
  // Geometry and timing
  // ----------------------------------------------------------------
  localparam int unsigned STAGES        = 80;
  localparam int unsigned FIFO_DEPTH    = 16;
  localparam int unsigned CLK_PERIOD_NS = 4;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_STAGE0 = 8'h08;
  localparam logic [7:0] ADDR_STAGE1 = 8'h0C;
  localparam logic [7:0] ADDR_STAGE2 = 8'h10;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_HOLD_BIT   = 0;
  localparam int unsigned CTRL_BLANK_BIT  = 1;
  localparam int unsigned STAT_OVF_BIT    = 0;
  localparam int unsigned STAT_LEVEL_LSB  = 4;
  localparam logic [1:0]  CTRL_RESET      = 2'h0;
  localparam logic        OVF_RESET       = 1'b0;

  // ----------------------------------------------------------------
  // Drive level codes for each common output
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    select_level_high   = 2'h0,
    unselect_level_high = 2'h1,
    unselect_level_low  = 2'h2,
    select_level_low    = 2'h3
  } lcrsd_level_e;

endpackage
`default_nettype wire

// ==== testbench/lcrsd_ctrl_model.sv ====
// Purpose: Timing controller model driving the scan link
// Assumes: One scan bit per call, shift clock idles low
// Notes:   Released data line shows the inverse of the last bit
`timescale 1ns/100ps
`default_nettype none

// --------------------------------------------------------------------
// Scan link controller model
// --------------------------------------------------------------------
module lcrsd_ctrl_model (
  // Clock and direction
  input  wire logic clock_i,
  input  wire logic dir_i,
  // Scan link
  output logic      line_shift_clock_o,
  output logic      left_o,
  output logic      right_o
);
  // Idle link
  initial
  begin
    line_shift_clock_o = 1'b0;
    left_o             = 1'b0;
    right_o            = 1'b1;
  end

  // One display line: clock high, fall, hold, release
  task automatic shift(input logic b, input int hi);
    @(posedge clock_i);
    line_shift_clock_o <= 1'b1;
    if (dir_i)
      right_o <= b; // Entry port follows direction
    else
      left_o <= b;
    repeat (hi) @(posedge clock_i);
    line_shift_clock_o <= 1'b0; // Fall samples the bit
    @(posedge clock_i);
    left_o  <= ~b; // Stale data hidden once hold is over
    right_o <= ~b;
  endtask
  // Duty set by how often the caller shifts
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Purpose: Self-checking bench for the row scan driver
// Assumes: Controller model drives the scan link
// Notes:   Read results checked from a queue by a monitor
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end

module tb_top;
  // Design inputs
  logic             clock_i   = 1'b0;
  logic             rst_b_i   = 1'b0;
  logic             dir       = 1'b0;
  logic             pol       = 1'b0;
  logic             blank_n   = 1'b1;
  logic [7:0]       reg_addr  = 8'h00;
  logic [31:0]      reg_wdata = 32'h0;
  logic             reg_write = 1'b0;
  logic             reg_read  = 1'b0;
  // Design outputs and link
  logic             lsc, m_left, m_right, l_o, l_oe_b, r_o, r_oe_b, rdy;
  logic [79:0][1:0] drv;
  logic [31:0]      rdata, rd_e;
  wire logic        left_w, right_w;
  // Bookkeeping
  int               n_mismatch = 0;
  int               n_checks   = 0;
  logic [79:0]      exp_stage  = '0;
  logic [31:0]      rd_exp[$];
  logic             rd_seen    = 1'b0;
  logic             b;

  always #2 clock_i = ~clock_i;
  // Wire level from both drivers of each two-way pin
  assign left_w  = l_oe_b ? m_left : l_o;
  assign right_w = r_oe_b ? m_right : r_o;

  lcrsd_driver lcrsd_driver_inst (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .line_shift_clock_i(lsc),
    .shift_direction_select_i(dir), .polarity_alternate_i(pol),
    .display_blank_n_i(blank_n), .left_chain_port_i(left_w),
    .left_chain_port_o(l_o), .left_chain_port_oe_b_o(l_oe_b),
    .right_chain_port_i(right_w), .right_chain_port_o(r_o),
    .right_chain_port_oe_b_o(r_oe_b), .common_drive_outputs_o(drv),
    .scan_ready_o(rdy), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_write_i(reg_write), .reg_read_i(reg_read), .reg_rdata_o(rdata));

  lcrsd_ctrl_model lcrsd_ctrl_model_inst (
    .clock_i(clock_i), .dir_i(dir), .line_shift_clock_o(lsc),
    .left_o(m_left), .right_o(m_right));

  // Expected drive level of one output
  function automatic logic [1:0] lvl(input logic s, p, bn);
    if (!bn)
      return lcrsd_pkg::select_level_low;
    if (!p)
      return s ? lcrsd_pkg::unselect_level_low : lcrsd_pkg::unselect_level_high;
    return s ? lcrsd_pkg::select_level_high : lcrsd_pkg::unselect_level_low;
  endfunction

  // Register port cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock_i);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock_i);
    reg_addr <= a;
    reg_read <= 1'b1;
    rd_exp.push_back(e);
    @(posedge clock_i);
    reg_read <= 1'b0;
  endtask

  // Monitor: read data in the cycle after the strobe
  always @(posedge clock_i)
    rd_seen <= reg_read;
  always @(negedge clock_i)
    if (rd_seen && rd_exp.size() > 0)
    begin
      rd_e = rd_exp.pop_front();
      `CHK(rdata, rd_e)
    end

  // Reference shift and full output check
  task automatic note_shift(input logic v);
    if (!dir)
      exp_stage = {exp_stage[78:0], v};
    else
      exp_stage = {v, exp_stage[79:1]};
  endtask
  task automatic check_all(input logic bn);
    @(negedge clock_i);
    for (int i = 0; i < 80; i++)
      `CHK(drv[i], lvl(exp_stage[i], pol, bn))
    `CHK(l_o, exp_stage[0])
    `CHK(r_o, exp_stage[79])
    `CHK(l_oe_b, ~dir)
    `CHK(r_oe_b, dir)
  endtask
  task automatic read_stages;
    rd(lcrsd_pkg::ADDR_STAGE0, exp_stage[31:0]);
    rd(lcrsd_pkg::ADDR_STAGE1, exp_stage[63:32]);
    rd(lcrsd_pkg::ADDR_STAGE2, {16'h0000, exp_stage[79:64]});
  endtask

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #80000;
    n_mismatch++;
    wrap_up();
  end

  // Main sequence
  initial
  begin
    void'($urandom(32'h71D3));
    repeat (2) @(posedge clock_i);
    `CHK(drv, {80{2'h3}})
    rst_b_i <= 1'b1;
    rd(lcrsd_pkg::ADDR_CTRL, 32'h0);
    rd(lcrsd_pkg::ADDR_STATUS, 32'h0);
    wr(8'hFC, 32'hFFFFFFFF);
    rd(8'hFC, 32'h0);
    rd(lcrsd_pkg::ADDR_CTRL, 32'h0);
    read_stages();
    // Random scan, direction, polarity and blanking
    for (int k = 0; k < 120; k++)
    begin
      @(posedge clock_i);
      dir     <= 1'($urandom_range(0, 1));
      pol     <= 1'($urandom_range(0, 1));
      blank_n <= ($urandom_range(0, 3) != 0);
      b = 1'($urandom_range(0, 1));
      lcrsd_ctrl_model_inst.shift(b, $urandom_range(1, 4));
      note_shift(b);
      repeat (4) @(posedge clock_i);
      check_all(blank_n);
      if (k % 20 == 0)
        read_stages();
    end
    // Force blank through the control register
    wr(lcrsd_pkg::ADDR_CTRL, 32'h2);
    repeat (2) @(posedge clock_i);
    check_all(1'b0);
    wr(lcrsd_pkg::ADDR_CTRL, 32'h1);
    rd(lcrsd_pkg::ADDR_CTRL, 32'h1);
    // Hold drain, fill FIFO until refused
    @(posedge clock_i);
    dir <= 1'b0;
    for (int k = 0; k < 16; k++)
    begin
      b = 1'($urandom_range(0, 1));
      lcrsd_ctrl_model_inst.shift(b, 1);
      note_shift(b);
    end
    @(negedge clock_i);
    `CHK(rdy, 1'b0)
    lcrsd_ctrl_model_inst.shift(~b, 1);
    rd(lcrsd_pkg::ADDR_STATUS, 32'h101);
    wr(lcrsd_pkg::ADDR_STATUS, 32'h1);
    rd(lcrsd_pkg::ADDR_STATUS, 32'h100);
    wr(lcrsd_pkg::ADDR_CTRL, 32'h0);
    repeat (40) @(posedge clock_i);
    check_all(blank_n);
    read_stages();
    rd(lcrsd_pkg::ADDR_STATUS, 32'h0);
    // Mid-run reset empties the chain and blanks the outputs
    @(posedge clock_i);
    rst_b_i <= 1'b0;
    @(negedge clock_i);
    `CHK(drv, {80{lcrsd_pkg::select_level_low}})
    @(posedge clock_i);
    rst_b_i <= 1'b1;
    exp_stage = '0;
    repeat (2) @(posedge clock_i);
    check_all(blank_n);
    read_stages();
    rd(lcrsd_pkg::ADDR_STATUS, 32'h0);
    repeat (4) @(posedge clock_i);
    wrap_up();
  end
endmodule
`default_nettype wire
